// ### bench/eac_top_props.sv
`timescale 1ns/1ns
module eac_top_props
   import eac_pkg::*;
(
   // clock and reset
   input wire logic         CLK,
   input wire logic         RST,
   // observed ports
   input wire eac_bus_req_t BUS_REQ,
   input wire logic [7:0]   RDATA,
   input wire logic         GLOBAL_IRQ_EN,
   input wire logic         FLASH_SELFPROG_ACTIVE,
   input wire logic         CPU_STALL,
   input wire logic         READY_IRQ,
   input wire eac_nv_cmd_t  NV_CMD
);
   // ======================================================
   // port relations, disabled while the core reset is high
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   a_rdata_idle: assert property (!BUS_REQ.rd |=> RDATA == 8'h00)
      else $error("read data not zero outside a read");
   a_ctrl_zero: assert property (BUS_REQ.rd && BUS_REQ.addr == EAC_OFS_CONTROL
      |=> RDATA[7:6] == 2'b00 && !RDATA[0]) else $error("control unused bits set");
   a_addr_high_zero: assert property (BUS_REQ.rd && BUS_REQ.addr == EAC_OFS_ADDR_HIGH
      |=> RDATA[7:4] == 4'h0) else $error("address high unused bits set");
   // stall and busy gaps hide a strobe the engine must refuse
   a_read_issue: assert property (BUS_REQ.wr && BUS_REQ.addr == EAC_OFS_CONTROL
      && BUS_REQ.wdata[0] && !CPU_STALL && !(NV_CMD.erase || NV_CMD.write)
      |=> NV_CMD.read) else $error("read strobe not issued");
   a_read_pulse: assert property (NV_CMD.read |=> !NV_CMD.read)
      else $error("array read longer than one cycle");
   a_read_stall: assert property ($rose(NV_CMD.read) |-> CPU_STALL [*4] ##1 !CPU_STALL)
      else $error("read stall not four cycles");
   a_prog_stall: assert property ($rose(CPU_STALL) && !NV_CMD.read
      |-> CPU_STALL [*2] ##1 !CPU_STALL) else $error("program stall not two cycles");
   a_phase_excl: assert property (!(NV_CMD.erase && NV_CMD.write))
      else $error("erase and write together");
   a_flash_block: assert property (FLASH_SELFPROG_ACTIVE [*4]
      |-> !$rose(NV_CMD.erase || NV_CMD.write)) else $error("started during flash work");
   a_ready_busy: assert property (NV_CMD.erase || NV_CMD.write |-> !READY_IRQ)
      else $error("ready interrupt while busy");
   a_ready_gie: assert property (READY_IRQ |-> $past(GLOBAL_IRQ_EN))
      else $error("ready interrupt without global enable");
endmodule

bind eac_top eac_top_props u_props (
   .CLK(CLK), .RST(RST), .BUS_REQ(BUS_REQ), .RDATA(RDATA), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
   .FLASH_SELFPROG_ACTIVE(FLASH_SELFPROG_ACTIVE), .CPU_STALL(CPU_STALL),
   .READY_IRQ(READY_IRQ), .NV_CMD(NV_CMD));

// ### bench/test_eac_top.sv
`timescale 1ns/1ns
module test_eac_top
   import eac_pkg::*;
;
   // ======================================================
   // stimulus and observed signals
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic         por = 1'b1;
   logic         gie = 1'b0;
   logic         flash = 1'b0;
   logic         rc = 1'b0;
   eac_bus_req_t req = '0;
   eac_nv_cmd_t  cmd;
   eac_bus_req_t unused;
   logic [7:0]   rdata;
   logic         stall;
   logic         rdy;
   logic         irq;
   int           error_cnt = 0;
   int           samples_checked = 0;
   // rc period off the clk grid so ticks drift in phase
   always #25 clk = ~clk;
   always #65 rc = ~rc;
   // array model: byte derived from the address
   wire logic [7:0] nv_rdata = cmd.addr[7:0] ^ {4'h0, cmd.addr[11:8]};
   eac_top #(.ATOMIC_RC_CYC(32), .SPLIT_RC_CYC(16), .CNT_W(15)) DUT (
      .CLK(clk), .RST(rst), .POR(por), .BUS_REQ(req), .BUS_UNUSED_NONE(unused),
      .RDATA(rdata), .GLOBAL_IRQ_EN(gie), .FLASH_SELFPROG_ACTIVE(flash),
      .CPU_STALL(stall), .READY_IRQ(rdy), .IRQ(irq), .RC_OSC(rc),
      .NV_RDATA(nv_rdata), .NV_CMD(cmd));
   // ======================================================
   // shared tasks
   task automatic conclude();
      if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(string n, logic [11:0] s, logic [11:0] e);
      samples_checked++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // one bus cycle; returns just after the taking edge so read data has landed
   task automatic op(logic [7:0] a, logic [7:0] d, logic w, logic r);
      req <= '{a, d, w, r};
      @(posedge clk);
      #1;
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      op(a, d, 1'b1, 1'b0);
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e, string n);
      op(a, 8'h00, 1'b0, 1'b1);
      chk(n, rdata, e);
   endtask
   task automatic idle(int n);
      repeat (n) op(8'h00, 8'h00, 1'b0, 1'b0);
   endtask
   // arm, then strobe on the third of the window's four cycles
   task automatic start(logic [7:0] m);
      wr(EAC_OFS_CONTROL, m | 8'h04);
      idle(2);
      wr(EAC_OFS_CONTROL, m | 8'h06);
   endtask
   // start one operation and count the cycles that the array phases stand
   task automatic run_op(logic [7:0] m, output int n, output logic [1:0] ph);
      n = 0;
      ph = 2'b00;
      start(m);
      for (int i = 0; i < 50 && (cmd.erase | cmd.write) !== 1'b1; i++) idle(1);
      while ((cmd.erase | cmd.write) === 1'b1 && n < 300) begin
         ph = ph | {cmd.erase, cmd.write};
         idle(1);
         n++;
      end
   endtask
   // ======================================================
   // scenarios
   task automatic t_reset();
      rd(EAC_OFS_CONTROL, 8'h00, "ctrl");
      rd(EAC_OFS_IRQ_MASK, 8'h00, "mask");
      chk("unused port", {11'h000, |unused}, 12'h000);
      wr(8'h30, 8'hff);
      rd(8'h30, 8'h00, "unmapped");
   endtask
   task automatic t_read();
      wr(EAC_OFS_ADDR_LOW, 8'h5a);
      wr(EAC_OFS_ADDR_HIGH, 8'hf3);
      rd(EAC_OFS_ADDR_HIGH, 8'h03, "addr high");
      rd(EAC_OFS_ADDR_LOW, 8'h5a, "addr low");
      wr(EAC_OFS_CONTROL, 8'h01);
      idle(5);
      rd(EAC_OFS_DATA, 8'h59, "read byte");
      rd(EAC_OFS_IRQ_STATUS, 8'h02, "read done");
      rd(EAC_OFS_IRQ_STATUS, 8'h00, "status clear");
   endtask
   task automatic t_arm();
      wr(EAC_OFS_CONTROL, 8'h04);
      rd(EAC_OFS_CONTROL, 8'h04, "armed");
      idle(4);
      rd(EAC_OFS_CONTROL, 8'h00, "expired");
      wr(EAC_OFS_CONTROL, 8'h02);
      rd(EAC_OFS_CONTROL, 8'h00, "late strobe");
      rd(EAC_OFS_IRQ_STATUS, 8'h04, "refused");
   endtask
   task automatic t_prog();
      wr(EAC_OFS_ADDR_LOW, 8'hc3);
      wr(EAC_OFS_ADDR_HIGH, 8'h0a);
      wr(EAC_OFS_DATA, 8'ha5);
      start(8'h28);
      // global enable only once the strobe has landed
      gie <= 1'b1;
      rd(EAC_OFS_CONTROL, 8'h2e, "busy");
      for (int i = 0; i < 50 && cmd.write !== 1'b1; i++) idle(1);
      chk("nv addr", cmd.addr, 12'hac3);
      chk("nv data", cmd.wdata, 12'h0a5);
      chk("no erase", cmd.erase, 1'b0);
      wr(EAC_OFS_ADDR_LOW, 8'h00);
      wr(EAC_OFS_CONTROL, 8'h01);
      wr(EAC_OFS_CONTROL, 8'h10);
      rd(EAC_OFS_ADDR_LOW, 8'hc3, "addr locked");
      rd(EAC_OFS_CONTROL, 8'h22, "mode kept");
      rd(EAC_OFS_IRQ_STATUS, 8'h08, "read refused");
      rst <= 1'b1;
      idle(2);
      rst <= 1'b0;
      rd(EAC_OFS_CONTROL, 8'h22, "over reset");
      wr(EAC_OFS_IRQ_MASK, 8'h01);
      for (int i = 0; i < 100 && irq !== 1'b1; i++) idle(1);
      rd(EAC_OFS_IRQ_STATUS, 8'h01, "prog done");
      idle(1);
      chk("irq low", irq, 1'b0);
      rd(EAC_OFS_CONTROL, 8'h20, "mode after");
   endtask
   task automatic t_ready();
      wr(EAC_OFS_CONTROL, 8'h08);
      idle(2);
      chk("ready", rdy, 1'b1);
      gie <= 1'b0;
      idle(2);
      chk("ready off", rdy, 1'b0);
   endtask
   task automatic t_block();
      int         n;
      logic [1:0] ph;
      flash <= 1'b1;
      start(8'h00);
      idle(4);
      rd(EAC_OFS_CONTROL, 8'h00, "flash busy");
      flash <= 1'b0;
      start(8'h30);
      idle(4);
      rd(EAC_OFS_CONTROL, 8'h30, "reserved");
      rd(EAC_OFS_IRQ_STATUS, 8'h04, "refusals");
      run_op(8'h00, n, ph);
      chk("phases", ph, 2'b11);
      chk("atomic len", n >= 76 && n <= 90, 1'b1);
      run_op(8'h10, n, ph);
      chk("erase only", ph, 2'b10);
      chk("erase len", n >= 36 && n <= 48, 1'b1);
   endtask
   // ======================================================
   // main sequence and watchdog
   initial begin
      repeat (6) @(posedge clk);
      #1;
      rst <= 1'b0;
      por <= 1'b0;
      t_reset();
      t_read();
      t_arm();
      t_prog();
      t_ready();
      t_block();
      conclude();
   end
   initial begin
      #200000;
      error_cnt++;
      conclude();
   end
endmodule

// ### logic/eac_pkg.sv
package eac_pkg;

   // ==========================================================
   // register map (byte offsets on the register port)
   // ==========================================================
   localparam logic [7:0] EAC_OFS_CONTROL    = 8'h1f;
   localparam logic [7:0] EAC_OFS_DATA       = 8'h20;
   localparam logic [7:0] EAC_OFS_ADDR_LOW   = 8'h21;
   localparam logic [7:0] EAC_OFS_ADDR_HIGH  = 8'h22;
   localparam logic [7:0] EAC_OFS_IRQ_STATUS = 8'h23;
   localparam logic [7:0] EAC_OFS_IRQ_MASK   = 8'h24;

   // ==========================================================
   // control register fields
   // ==========================================================
   localparam int EAC_CTL_READ_STROBE = 0;
   localparam int EAC_CTL_PROG_STROBE = 1;
   localparam int EAC_CTL_MASTER_EN   = 2;
   localparam int EAC_CTL_READY_IE    = 3;
   localparam int EAC_CTL_MODE_LO     = 4;
   localparam int EAC_CTL_MODE_HI     = 5;

   localparam int EAC_ADDR_W = 12;

   // programming modes
   typedef enum logic [1:0] {
      EAC_MODE_ATOMIC = 2'b00,
      EAC_MODE_ERASE  = 2'b01,
      EAC_MODE_WRITE  = 2'b10,
      EAC_MODE_RSVD   = 2'b11
   } eac_mode_t;

   // programming engine states, gray along idle-erase-write
   typedef enum logic [1:0] {
      EAC_ST_IDLE  = 2'b00,
      EAC_ST_ERASE = 2'b01,
      EAC_ST_WRITE = 2'b11
   } eac_state_t;

   // ==========================================================
   // reset values and cycle counts
   // ==========================================================
   localparam eac_mode_t   EAC_MODE_RST      = EAC_MODE_ATOMIC;
   localparam logic [3:0]  EAC_IRQ_MASK_RST  = 4'h0;
   localparam logic [2:0]  EAC_ARM_CYCLES    = 3'h4;
   localparam logic [2:0]  EAC_STALL_PROG    = 3'h2;
   localparam logic [2:0]  EAC_STALL_READ    = 3'h4;
   localparam int          EAC_ATOMIC_RC_CYC = 26368;
   localparam int          EAC_SPLIT_RC_CYC  = 13960;
   localparam int          EAC_ATOMIC_TIME_US = 3400;
   localparam int          EAC_SPLIT_TIME_US  = 1800;

   // ==========================================================
   // interrupt status bits
   // ==========================================================
   localparam int EAC_EV_PROG_DONE    = 0;
   localparam int EAC_EV_READ_DONE    = 1;
   localparam int EAC_EV_PROG_REFUSED = 2;
   localparam int EAC_EV_READ_REFUSED = 3;
   localparam int EAC_EV_W            = 4;

   // ==========================================================
   // carriers
   // ==========================================================
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } eac_bus_req_t;

   typedef struct packed {
      logic [EAC_ADDR_W-1:0] addr;
      logic [7:0]            wdata;
      logic                  erase;
      logic                  write;
      logic                  read;
   } eac_nv_cmd_t;

endpackage

// ### logic/eac_prog_timer.sv
`timescale 1ns/1ns
// counts oscillator ticks down from a loaded value
module eac_prog_timer #(
   parameter int CNT_W = 15
) (
   // clock and engine reset
   input  wire logic             clk,
   input  wire logic             por,
   // control
   input  wire logic             start,
   input  wire logic [CNT_W-1:0] load,
   input  wire logic             tick,
   // status
   output logic                  busy,
   output logic                  done
);

   logic [CNT_W-1:0] remain;

   initial begin
      if (CNT_W < 2 || CNT_W > 24) begin
         $error("eac_prog_timer: CNT_W out of range");
      end
   end

   // ======================================================
   // countdown; a start during the done cycle restarts it
   // ======================================================
   always_ff @(posedge clk or posedge por) begin
      if (por) begin
         remain <= '0;
         busy   <= 1'b0;
         done   <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            remain <= load;
            busy   <= 1'b1;
         end else if (busy && tick) begin
            if (remain <= CNT_W'(1)) begin
               remain <= '0;
               busy   <= 1'b0;
               done   <= 1'b1;
            end else begin
               remain <= remain - CNT_W'(1);
            end
         end
      end
   end

endmodule

// ### logic/eac_top.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
module eac_top
   import eac_pkg::*;
#(
   parameter int ATOMIC_RC_CYC = EAC_ATOMIC_RC_CYC,
   parameter int SPLIT_RC_CYC  = EAC_SPLIT_RC_CYC,
   parameter int CNT_W         = 15
) (
   // clock and resets
   input  wire logic         CLK,
   input  wire logic         RST,
   input  wire logic         POR,
   // register port
   input  wire eac_bus_req_t BUS_REQ,
   output eac_pkg::eac_bus_req_t BUS_UNUSED_NONE,
   output logic [7:0]        RDATA,
   // core side
   input  wire logic         GLOBAL_IRQ_EN,
   input  wire logic         FLASH_SELFPROG_ACTIVE,
   output logic              CPU_STALL,
   output logic              READY_IRQ,
   output logic              IRQ,
   // calibrated oscillator, asynchronous to CLK
   input  wire logic         RC_OSC,
   // array side
   input  wire logic [7:0]   NV_RDATA,
   output eac_nv_cmd_t       NV_CMD
);

   // ==========================================================
   // declarations
   // ==========================================================
   logic [EAC_ADDR_W-1:0] nv_byte_address;
   logic [7:0]            nv_data_byte;
   eac_mode_t             prog_mode_field;
   logic                  ready_irq_enable;
   logic                  master_prog_enable;
   logic [2:0]            arm_cnt;
   logic [2:0]            stall_cnt;
   logic [EAC_EV_W-1:0]   irq_status;
   logic [EAC_EV_W-1:0]   irq_mask;
   logic [EAC_EV_W-1:0]   events;
   eac_state_t            state;
   logic                  prog_strobe;
   logic                  rc_meta;
   logic                  rc_sync;
   logic                  rc_prev;
   logic                  rc_tick;
   logic                  wr_ctl;
   logic                  prog_req;
   logic                  prog_start;
   logic                  prog_refused;
   logic                  read_req;
   logic                  read_ok;
   logic                  timer_start;
   logic [CNT_W-1:0]      timer_load;
   logic                  timer_busy;
   logic                  timer_done;
   logic [7:0]            next_rdata;

   initial begin
      if (ATOMIC_RC_CYC < 4 || ATOMIC_RC_CYC >= (1 << CNT_W)) begin
         $error("eac_top: ATOMIC_RC_CYC does not fit the timer");
      end
      if (SPLIT_RC_CYC < 2 || SPLIT_RC_CYC >= (1 << CNT_W)) begin
         $error("eac_top: SPLIT_RC_CYC does not fit the timer");
      end
   end

   // the port has no unused outputs; this struct reads constant zero
   assign BUS_UNUSED_NONE = '0;

   // ==========================================================
   // request decode
   // ==========================================================
   assign wr_ctl   = BUS_REQ.wr && (BUS_REQ.addr == EAC_OFS_CONTROL);
   assign prog_strobe = (state != EAC_ST_IDLE);
   assign prog_req = wr_ctl && BUS_REQ.wdata[EAC_CTL_PROG_STROBE];
   // arming window, idle engine, idle flash and a real mode are all needed
   assign prog_start = prog_req && master_prog_enable
                    && !prog_strobe
                    && !FLASH_SELFPROG_ACTIVE
                    && (prog_mode_field != EAC_MODE_RSVD);
   assign prog_refused = prog_req && !prog_start;
   assign read_req = wr_ctl && BUS_REQ.wdata[EAC_CTL_READ_STROBE];
   assign read_ok  = read_req && !prog_strobe;

   // ==========================================================
   // oscillator synchroniser; the first stage feeds no logic
   // ==========================================================
   always_ff @(posedge CLK or posedge POR) begin
      if (POR) begin
         rc_meta <= 1'b0;
         rc_sync <= 1'b0;
         rc_prev <= 1'b0;
      end else begin
         rc_meta <= RC_OSC;
         rc_sync <= rc_meta;
         rc_prev <= rc_sync;
      end
   end

   // one tick per rising oscillator edge
   assign rc_tick = rc_sync && !rc_prev;

   // ==========================================================
   // programming engine; on POR only, so a core reset never aborts it
   // ==========================================================
   always_ff @(posedge CLK or posedge POR) begin
      if (POR) begin
         state <= EAC_ST_IDLE;
      end else begin
         case (state)
            EAC_ST_IDLE: begin
               if (prog_start) begin
                  if (prog_mode_field == EAC_MODE_WRITE) begin
                     state <= EAC_ST_WRITE;
                  end else begin
                     state <= EAC_ST_ERASE;
                  end
               end
            end
            EAC_ST_ERASE: begin
               if (timer_done) begin
                  // atomic runs on into the write half
                  if (prog_mode_field == EAC_MODE_ATOMIC) begin
                     state <= EAC_ST_WRITE;
                  end else begin
                     state <= EAC_ST_IDLE;
                  end
               end
            end
            EAC_ST_WRITE: begin
               if (timer_done) begin
                  state <= EAC_ST_IDLE;
               end
            end
            default: begin
               state <= EAC_ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // timer load: atomic splits the full count in two, the write half taking any odd tick
   // ==========================================================
   always_comb begin
      timer_start = 1'b0;
      timer_load  = CNT_W'(SPLIT_RC_CYC);
      if (prog_start) begin
         timer_start = 1'b1;
         if (prog_mode_field == EAC_MODE_ATOMIC) begin
            timer_load = CNT_W'(ATOMIC_RC_CYC / 2);
         end else begin
            timer_load = CNT_W'(SPLIT_RC_CYC);
         end
      end else if (state == EAC_ST_ERASE && timer_done
                   && prog_mode_field == EAC_MODE_ATOMIC) begin
         timer_start = 1'b1;
         timer_load  = CNT_W'(ATOMIC_RC_CYC - ATOMIC_RC_CYC / 2);
      end
   end

   eac_prog_timer #(
      .CNT_W (CNT_W)
   ) u_timer (
      .clk   (CLK),
      .por   (POR),
      .start (timer_start),
      .load  (timer_load),
      .tick  (rc_tick),
      .busy  (timer_busy),
      .done  (timer_done)
   );

   // ==========================================================
   // mode field: on POR only; the core reset clears it when idle
   // ==========================================================
   always_ff @(posedge CLK or posedge POR) begin
      if (POR) begin
         prog_mode_field <= EAC_MODE_RST;
      end else if (RST) begin
         if (!prog_strobe) begin
            prog_mode_field <= EAC_MODE_RST;
         end
      end else if (wr_ctl && !prog_strobe) begin
         prog_mode_field <= eac_mode_t'(
            BUS_REQ.wdata[EAC_CTL_MODE_HI:EAC_CTL_MODE_LO]);
      end
   end

   // ==========================================================
   // ready interrupt enable
   // ==========================================================
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ready_irq_enable <= 1'b0;
      end else if (wr_ctl) begin
         ready_irq_enable <= BUS_REQ.wdata[EAC_CTL_READY_IE];
      end
   end

   // ==========================================================
   // master enable: an arming window that runs out by itself
   // ==========================================================
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         master_prog_enable <= 1'b0;
         arm_cnt            <= 3'h0;
      end else if (wr_ctl) begin
         // any control write re-arms or disarms; the strobe itself may
         // land in the same write only if the window was already open
         master_prog_enable <= BUS_REQ.wdata[EAC_CTL_MASTER_EN];
         arm_cnt            <= EAC_ARM_CYCLES - 3'h1;
      end else if (master_prog_enable) begin
         if (arm_cnt == 3'h0) begin
            master_prog_enable <= 1'b0;
         end else begin
            arm_cnt <= arm_cnt - 3'h1;
         end
      end
   end

   // ==========================================================
   // address register, frozen while programming
   // ==========================================================
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         nv_byte_address <= '0;
      end else if (BUS_REQ.wr && !prog_strobe) begin
         if (BUS_REQ.addr == EAC_OFS_ADDR_LOW) begin
            nv_byte_address[7:0] <= BUS_REQ.wdata;
         end else if (BUS_REQ.addr == EAC_OFS_ADDR_HIGH) begin
            nv_byte_address[EAC_ADDR_W-1:8] <= BUS_REQ.wdata[EAC_ADDR_W-9:0];
         end
      end
   end

   // ==========================================================
   // data register: written by software, loaded by an array read
   // ==========================================================
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         nv_data_byte <= 8'h00;
      end else if (NV_CMD.read) begin
         nv_data_byte <= NV_RDATA;
      end else if (BUS_REQ.wr && BUS_REQ.addr == EAC_OFS_DATA) begin
         nv_data_byte <= BUS_REQ.wdata;
      end
   end

   // ==========================================================
   // array command; address and data are captured at the start
   // so later register writes cannot disturb a running operation
   // ==========================================================
   always_ff @(posedge CLK or posedge POR) begin
      if (POR) begin
         NV_CMD <= '0;
      end else begin
         NV_CMD.erase <= (state == EAC_ST_ERASE);
         NV_CMD.write <= (state == EAC_ST_WRITE);
         NV_CMD.read  <= read_ok;
         if (prog_start) begin
            NV_CMD.addr  <= nv_byte_address;
            NV_CMD.wdata <= nv_data_byte;
         end else if (!prog_strobe) begin
            NV_CMD.addr  <= nv_byte_address;
         end
      end
   end

   // ==========================================================
   // core stall: two cycles after a start, four after a read with no start in the same write
   // ==========================================================
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         stall_cnt <= 3'h0;
         CPU_STALL <= 1'b0;
      end else if (prog_start) begin
         stall_cnt <= EAC_STALL_PROG;
         CPU_STALL <= 1'b1;
      end else if (read_ok) begin
         stall_cnt <= EAC_STALL_READ;
         CPU_STALL <= 1'b1;
      end else begin
         if (stall_cnt != 3'h0) begin
            stall_cnt <= stall_cnt - 3'h1;
         end
         CPU_STALL <= (stall_cnt > 3'h1);
      end
   end

   // ==========================================================
   // interrupts: sticky status, cleared by reading it
   // ==========================================================
   always_comb begin
      events                      = '0;
      events[EAC_EV_PROG_DONE]    = prog_strobe && timer_done && state == EAC_ST_WRITE
                                    || state == EAC_ST_ERASE && timer_done
                                       && prog_mode_field == EAC_MODE_ERASE;
      events[EAC_EV_READ_DONE]    = NV_CMD.read;
      events[EAC_EV_PROG_REFUSED] = prog_refused;
      events[EAC_EV_READ_REFUSED] = read_req && !read_ok;
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         irq_status <= '0;
      end else if (BUS_REQ.rd && BUS_REQ.addr == EAC_OFS_IRQ_STATUS) begin
         // a new event in the read cycle survives the clear
         irq_status <= events;
      end else begin
         irq_status <= irq_status | events;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         irq_mask <= EAC_IRQ_MASK_RST;
      end else if (BUS_REQ.wr && BUS_REQ.addr == EAC_OFS_IRQ_MASK) begin
         irq_mask <= BUS_REQ.wdata[EAC_EV_W-1:0];
      end
   end

   // registered outputs; a cycle later than their cause
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         IRQ       <= 1'b0;
         READY_IRQ <= 1'b0;
      end else begin
         IRQ       <= |(irq_status & irq_mask);
         READY_IRQ <= ready_irq_enable && GLOBAL_IRQ_EN && !prog_strobe;
      end
   end

   // ==========================================================
   // read data, valid only in the cycle after the read strobe
   // ==========================================================
   always_comb begin
      next_rdata = 8'h00;
      case (BUS_REQ.addr)
         EAC_OFS_CONTROL: begin
            next_rdata[EAC_CTL_MODE_HI:EAC_CTL_MODE_LO] = prog_mode_field;
            next_rdata[EAC_CTL_READY_IE]    = ready_irq_enable;
            next_rdata[EAC_CTL_MASTER_EN]   = master_prog_enable;
            next_rdata[EAC_CTL_PROG_STROBE] = prog_strobe;
         end
         EAC_OFS_DATA: begin
            next_rdata = nv_data_byte;
         end
         EAC_OFS_ADDR_LOW: begin
            next_rdata = nv_byte_address[7:0];
         end
         EAC_OFS_ADDR_HIGH: begin
            next_rdata[EAC_ADDR_W-9:0] = nv_byte_address[EAC_ADDR_W-1:8];
         end
         EAC_OFS_IRQ_STATUS: begin
            next_rdata[EAC_EV_W-1:0] = irq_status;
         end
         EAC_OFS_IRQ_MASK: begin
            next_rdata[EAC_EV_W-1:0] = irq_mask;
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         RDATA <= 8'h00;
      end else if (BUS_REQ.rd) begin
         RDATA <= next_rdata;
      end else begin
         RDATA <= 8'h00;
      end
   end

endmodule
